/* File: rtl/zero_point_calibration_sequencer.sv */
// Zero-point calibration sequencer: drift and timer triggers, valve phase walk,
// stability check, zero adoption and freezing of measured values.
// Assumes live transmitter values arrive digitally each cycle and one AHB-Lite master.
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

// Functional notes
// - Start calibration when cell temperature drifts past limit since last calibration.
// - Start calibration when system pressure drifts past its own limit.
// - Start calibration when the interval expires without drift.
// - Pressure from transmitter static value, else sensor, else not monitored.
// - In split-range operation both transmitters are calibrated together.
// - Live digital readings stay live; derived differential pressure frozen during calibration.
// - In measuring mode show remaining time or waiting-for-external-trigger.
// - Pressure, temperature and differential inputs hold last values during calibration.
// - Totaliser keeps counting with last valid values during calibration.
// - Status output flags calibration in progress.
// - Directly forwarded loop current is held on the analog output.
// - Triggers: timer expiry, temperature or pressure drift, external input.
// - First isolate transmitter from process, then join its chambers.
// - Let it settle; adopt a steady reading near old zero as new zero.
// - First separate the chambers, then reconnect to the process.
// - Wait a settling period before measurement resumes.
// - Manual set-zero only accepted once zero condition is established.
// - Manual set-zero ignores displayed value and adopts transmitter reading.
// - Manual restore reconnects, then re-enables measurement after settling.
// - Manual ventilation toggles valves repeatedly, only for solenoid and wet media.
// - Timer switchable on or off; interval given in minutes.
// - Stability counted in check cycles of about 250 ms within max fluctuation.
// - Skip new zero when deviation from old zero exceeds the maximum.
module zero_point_calibration_sequencer
	import zero_cal_pkg::*;
#(
	parameter int CLK_HZ            = 250000000,
	parameter int VALVE_STEP_CYCLES = 250000000
) (
	// Clock and reset.
	input  wire logic                    clk_sys_i,
	input  wire logic                    reset_n_i,
	// AHB-Lite slave.
	input  wire logic                    hsel_i,
	input  wire logic [31:0]             haddr_i,
	input  wire logic [1:0]              htrans_i,
	input  wire logic                    hwrite_i,
	input  wire logic [2:0]              hsize_i,
	input  wire logic [31:0]             hwdata_i,
	input  wire logic                    hready_i,
	output logic      [31:0]             hrdata_o,
	output logic                         hreadyout_o,
	output logic                         hresp_o,
	// Measurement and trigger inputs.
	input  wire zero_cal_pkg::meas_type  meas_i,
	input  wire logic                    meas_valid_i,
	input  wire logic                    ext_trigger_i,
	// Measurement outputs.
	output logic signed [15:0]           digital_diff_pressure_first_o,
	output logic signed [15:0]           digital_diff_pressure_second_o,
	output logic signed [15:0]           derived_diff_pressure_o,
	output logic signed [15:0]           derived_diff_pressure_second_o,
	output zero_cal_pkg::meas_type       held_meas_o,
	output logic        [15:0]           analog_output_one_o,
	output logic        [31:0]           totaliser_o,
	// Valve unit and control station.
	output zero_cal_pkg::valve_type      valve_o,
	output logic                         cal_active_o
);
	import zero_cal_pkg::*;

	localparam int CHECK_CYCLES = CLK_HZ / MS_PER_S * CHECK_MS;

	if (CLK_HZ < MS_PER_S || VALVE_STEP_CYCLES < 1) begin : g_bad_param
		$error("Clock rate or valve step time out of range.");
	end

	typedef struct packed {
		phase_type          ph;
		logic [31:0]        step;
		logic [31:0]        sec_div;
		logic [31:0]        chk_div;
		logic [31:0]        sec_cnt;
		logic [31:0]        remain;
		logic [15:0]        chk_n;
		logic [15:0]        vent_n;
		logic signed [15:0] prev1;
		logic signed [15:0] prev2;
		logic signed [15:0] zero1;
		logic signed [15:0] zero2;
		logic signed [15:0] ref_t;
		logic signed [15:0] ref_p;
		logic signed [15:0] dp1;
		logic signed [15:0] dp2;
		meas_type           held;
		logic               zero_cond;
		logic               zero_skip;
		logic               manual;
		logic [31:0]        total;
		logic [CTRL_W-1:0]  ctrl;
		logic [15:0]        timer_min;
		logic [15:0]        temp_lim;
		logic [15:0]        pres_lim;
		logic [15:0]        dp_dev;
		logic [15:0]        fluct;
		logic [15:0]        checks;
		logic [15:0]        settle_s;
		logic [15:0]        timeout_s;
		logic [15:0]        vent_cyc;
		logic               a_sel;
		logic               a_wr;
		logic [7:0]         a_addr;
		logic               rd_wait;
		logic [31:0]        rdata;
	} state_type;

	state_type s_r;
	state_type s_nxt;

	function automatic logic [16:0] adiff(input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		return d[16] ? 17'(-d) : d;
	endfunction

	function automatic logic exceeds(input logic signed [15:0] a, input logic signed [15:0] b,
		input logic [15:0] lim);
		return adiff(a, b) > {1'b0, lim};
	endfunction

	logic               split;
	logic               press_ok;
	logic signed [15:0] press_now;
	logic               sec_tick;
	logic               chk_tick;
	logic               step_done;
	logic               busy;
	logic               drift;
	logic               timer_due;
	logic [4:0]         cmd;
	logic               cmd_wr;
	logic               stable;
	logic [31:0]        rd_mux;

	always_comb begin
		split     = s_r.ctrl[CTRL_SPLIT];
		press_ok  = s_r.ctrl[CTRL_STATIC_OK] | s_r.ctrl[CTRL_SENSOR_OK];
		press_now = s_r.ctrl[CTRL_STATIC_OK] ? meas_i.static_press : meas_i.sensor_press;
		sec_tick  = s_r.sec_div == 32'(CLK_HZ - 1);
		chk_tick  = s_r.chk_div == 32'(CHECK_CYCLES - 1);
		step_done = s_r.step >= 32'(VALVE_STEP_CYCLES - 1);
		busy      = s_r.ph != PH_MEASURE;
		drift     = exceeds(meas_i.cell_temp, s_r.ref_t, s_r.temp_lim)
			| (press_ok & exceeds(press_now, s_r.ref_p, s_r.pres_lim));
		timer_due = s_r.ctrl[CTRL_TIMER_EN] & (s_r.remain == 32'h0000_0000);
		cmd_wr    = s_r.a_sel & s_r.a_wr & (s_r.a_addr == CMD_OFS);
		cmd       = cmd_wr ? hwdata_i[4:0] : 5'h00;
		stable    = ~exceeds(meas_i.ddp_first, s_r.prev1, s_r.fluct)
			& (~split | ~exceeds(meas_i.ddp_second, s_r.prev2, s_r.fluct));
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (s_r.a_addr == CTRL_OFS) begin
			rd_mux = 32'(s_r.ctrl);
		end else if (s_r.a_addr == TIMER_OFS) begin
			rd_mux = 32'(s_r.timer_min);
		end else if (s_r.a_addr == TEMP_LIM_OFS) begin
			rd_mux = 32'(s_r.temp_lim);
		end else if (s_r.a_addr == PRES_LIM_OFS) begin
			rd_mux = 32'(s_r.pres_lim);
		end else if (s_r.a_addr == DP_DEV_OFS) begin
			rd_mux = 32'(s_r.dp_dev);
		end else if (s_r.a_addr == FLUCT_OFS) begin
			rd_mux = 32'(s_r.fluct);
		end else if (s_r.a_addr == CHECKS_OFS) begin
			rd_mux = 32'(s_r.checks);
		end else if (s_r.a_addr == SETTLE_OFS) begin
			rd_mux = 32'(s_r.settle_s);
		end else if (s_r.a_addr == TIMEOUT_OFS) begin
			rd_mux = 32'(s_r.timeout_s);
		end else if (s_r.a_addr == VENT_OFS) begin
			rd_mux = 32'(s_r.vent_cyc);
		end else if (s_r.a_addr == STATUS_OFS) begin
			// Waiting for an external trigger shows in bit 5 while measuring untimed.
			rd_mux = {24'h00_0000, s_r.zero_skip, s_r.zero_cond,
				~busy & ~s_r.ctrl[CTRL_TIMER_EN], busy, 4'(s_r.ph)};
		end else if (s_r.a_addr == REMAIN_OFS) begin
			rd_mux = s_r.ctrl[CTRL_TIMER_EN] ? s_r.remain : 32'h0000_0000;
		end else if (s_r.a_addr == ZERO_OFS) begin
			rd_mux = {s_r.zero2, s_r.zero1};
		end
	end

	always_comb begin
		s_nxt = s_r;

		// Bus address phase; a read costs one wait state so the answer comes from a flop.
		s_nxt.rd_wait = 1'b0;
		if (s_r.rd_wait) begin
			s_nxt.rdata = rd_mux;
			s_nxt.a_sel = 1'b0;
		end else if (hready_i) begin
			s_nxt.a_sel  = hsel_i & htrans_i[1];
			s_nxt.a_wr   = hwrite_i;
			s_nxt.a_addr = haddr_i[7:0];
			s_nxt.rd_wait = hsel_i & htrans_i[1] & ~hwrite_i;
		end
		if (s_r.a_sel & s_r.a_wr) begin
			if (s_r.a_addr == CTRL_OFS) begin
				s_nxt.ctrl = hwdata_i[CTRL_W-1:0];
			end else if (s_r.a_addr == TIMER_OFS) begin
				s_nxt.timer_min = hwdata_i[15:0];
				s_nxt.remain    = 32'(hwdata_i[15:0]) * S_PER_MIN;
			end else if (s_r.a_addr == TEMP_LIM_OFS) begin
				s_nxt.temp_lim = hwdata_i[15:0];
			end else if (s_r.a_addr == PRES_LIM_OFS) begin
				s_nxt.pres_lim = hwdata_i[15:0];
			end else if (s_r.a_addr == DP_DEV_OFS) begin
				s_nxt.dp_dev = hwdata_i[15:0];
			end else if (s_r.a_addr == FLUCT_OFS) begin
				s_nxt.fluct = hwdata_i[15:0];
			end else if (s_r.a_addr == CHECKS_OFS) begin
				s_nxt.checks = hwdata_i[15:0];
			end else if (s_r.a_addr == SETTLE_OFS) begin
				s_nxt.settle_s = hwdata_i[15:0];
			end else if (s_r.a_addr == TIMEOUT_OFS) begin
				s_nxt.timeout_s = hwdata_i[15:0];
			end else if (s_r.a_addr == VENT_OFS) begin
				s_nxt.vent_cyc = hwdata_i[15:0];
			end
		end

		// Free-running prescalers for seconds and check cycles.
		s_nxt.sec_div = sec_tick ? 32'h0000_0000 : s_r.sec_div + 32'h0000_0001;
		s_nxt.chk_div = chk_tick ? 32'h0000_0000 : s_r.chk_div + 32'h0000_0001;
		s_nxt.step    = s_r.step + 32'h0000_0001;
		if (sec_tick) begin
			s_nxt.sec_cnt = s_r.sec_cnt + 32'h0000_0001;
		end

		// Totaliser runs on every sample, fed from the held value while frozen.
		if (meas_valid_i) begin
			s_nxt.total = s_r.total + 32'(s_r.dp1);
		end

		// Inputs track only while measuring and hold their last value otherwise.
		if (~busy) begin
			s_nxt.held = meas_i;
			s_nxt.dp1  = meas_i.ddp_first - s_r.zero1;
			s_nxt.dp2  = meas_i.ddp_second - s_r.zero2;
		end

		case (s_r.ph)
			PH_MEASURE: begin
				if (s_r.ctrl[CTRL_TIMER_EN] & sec_tick & (s_r.remain != 32'h0000_0000)) begin
					s_nxt.remain = s_r.remain - 32'h0000_0001;
				end
				s_nxt.manual = 1'b0;
				s_nxt.step   = 32'h0000_0000;
				if (s_r.ctrl[CTRL_HART_SRC] & (drift | timer_due | ext_trigger_i
					| cmd[CMD_START] | cmd[CMD_EST_ZC])) begin
					s_nxt.ph        = PH_ISOLATE;
					s_nxt.manual    = cmd[CMD_EST_ZC] & ~cmd[CMD_START];
					s_nxt.zero_skip = 1'b0;
				end else if (cmd[CMD_VENT] & s_r.ctrl[CTRL_SOLENOID]
					& s_r.ctrl[CTRL_WET_MEDIA]) begin
					s_nxt.ph     = PH_VENT;
					s_nxt.vent_n = 16'h0000;
				end
			end
			PH_ISOLATE: begin
				if (step_done) begin
					s_nxt.ph   = PH_JOIN;
					s_nxt.step = 32'h0000_0000;
				end
			end
			PH_JOIN: begin
				if (step_done) begin
					s_nxt.zero_cond = 1'b1;
					s_nxt.step      = 32'h0000_0000;
					s_nxt.sec_cnt   = 32'h0000_0000;
					s_nxt.chk_n     = 16'h0000;
					s_nxt.ph        = s_r.manual ? PH_HOLD_ZERO : PH_CALIB;
				end
			end
			PH_CALIB: begin
				if (chk_tick) begin
					s_nxt.prev1 = meas_i.ddp_first;
					s_nxt.prev2 = meas_i.ddp_second;
					s_nxt.chk_n = stable ? s_r.chk_n + 16'h0001 : 16'h0000;
				end
				if (chk_tick & stable & (s_r.chk_n + 16'h0001 >= s_r.checks)) begin
					if (exceeds(meas_i.ddp_first, s_r.zero1, s_r.dp_dev)
						| (split & exceeds(meas_i.ddp_second, s_r.zero2, s_r.dp_dev))) begin
						s_nxt.zero_skip = 1'b1;
					end else begin
						s_nxt.zero1 = meas_i.ddp_first;
						if (split) begin
							s_nxt.zero2 = meas_i.ddp_second;
						end
					end
					s_nxt.ph   = PH_SEPARATE;
					s_nxt.step = 32'h0000_0000;
				end else if (s_r.sec_cnt >= 32'(s_r.timeout_s)) begin
					// A transmitter that never steadies keeps its old zero.
					s_nxt.zero_skip = 1'b1;
					s_nxt.ph        = PH_SEPARATE;
					s_nxt.step      = 32'h0000_0000;
				end
			end
			PH_HOLD_ZERO: begin
				if (cmd[CMD_SET_Z] & s_r.zero_cond) begin
					s_nxt.zero1 = meas_i.ddp_first;
					if (split) begin
						s_nxt.zero2 = meas_i.ddp_second;
					end
				end
				if (cmd[CMD_RESTORE]) begin
					s_nxt.ph   = PH_SEPARATE;
					s_nxt.step = 32'h0000_0000;
				end
			end
			PH_SEPARATE: begin
				s_nxt.zero_cond = 1'b0;
				if (step_done) begin
					s_nxt.ph   = PH_RECONNECT;
					s_nxt.step = 32'h0000_0000;
				end
			end
			PH_RECONNECT: begin
				if (step_done) begin
					s_nxt.ph      = PH_SETTLE;
					s_nxt.sec_cnt = 32'h0000_0000;
				end
			end
			PH_SETTLE: begin
				if (s_r.sec_cnt >= 32'(s_r.settle_s)) begin
					s_nxt.ph     = PH_MEASURE;
					s_nxt.ref_t  = meas_i.cell_temp;
					s_nxt.ref_p  = press_now;
					s_nxt.remain = 32'(s_r.timer_min) * S_PER_MIN;
				end
			end
			PH_VENT: begin
				if (step_done) begin
					s_nxt.step   = 32'h0000_0000;
					s_nxt.vent_n = s_r.vent_n + 16'h0001;
					if (s_r.vent_n + 16'h0001 >= {s_r.vent_cyc[14:0], 1'b0}) begin
						s_nxt.ph      = PH_SETTLE;
						s_nxt.sec_cnt = 32'h0000_0000;
					end
				end
			end
			default: begin
				s_nxt.ph = PH_MEASURE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			s_r           <= '0;
			s_r.ph        <= PH_MEASURE;
			s_r.ctrl      <= CTRL_RST;
			s_r.timer_min <= TIMER_RST;
			s_r.remain    <= 32'(TIMER_RST) * S_PER_MIN;
			s_r.temp_lim  <= LIMIT_RST;
			s_r.pres_lim  <= LIMIT_RST;
			s_r.dp_dev    <= LIMIT_RST;
			s_r.fluct     <= LIMIT_RST;
			s_r.checks    <= CHECKS_RST;
			s_r.settle_s  <= SETTLE_RST;
			s_r.timeout_s <= TMO_RST;
			s_r.vent_cyc  <= VENT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Live readings stay live; the derived values and the held input copy are frozen.
	assign digital_diff_pressure_first_o  = meas_i.ddp_first;
	assign digital_diff_pressure_second_o = meas_i.ddp_second;
	assign derived_diff_pressure_o        = s_r.dp1;
	assign derived_diff_pressure_second_o = s_r.dp2;
	assign held_meas_o                    = s_r.held;
	// Direct forwarding of the loop current follows the held copy.
	assign analog_output_one_o = s_r.ctrl[CTRL_AO_DIRECT] ? s_r.held.loop_current : 16'h0000;
	assign totaliser_o         = s_r.total;
	// Ventilation flips the process valve; chambers never join on a live process.
	assign valve_o.isolate = (s_r.ph == PH_ISOLATE) | (s_r.ph == PH_JOIN) | (s_r.ph == PH_CALIB)
		| (s_r.ph == PH_HOLD_ZERO) | (s_r.ph == PH_SEPARATE)
		| ((s_r.ph == PH_VENT) & s_r.vent_n[0]);
	assign valve_o.join_chambers = (s_r.ph == PH_JOIN) | (s_r.ph == PH_CALIB)
		| (s_r.ph == PH_HOLD_ZERO);
	assign cal_active_o = busy;
	assign hrdata_o     = s_r.rdata;
	assign hreadyout_o  = ~s_r.rd_wait;
	assign hresp_o      = 1'b0;

endmodule

/* File: rtl/zero_cal_pkg.sv */
// Package for the zero-point calibration sequencer: register map, field positions,
// phase encoding and the carrier structs. Assumes a 32-bit AHB-Lite register bus.
package zero_cal_pkg;

	// Register byte offsets.
	localparam logic [7:0] CTRL_OFS     = 8'h00;
	localparam logic [7:0] CMD_OFS      = 8'h04;
	localparam logic [7:0] TIMER_OFS    = 8'h08;
	localparam logic [7:0] TEMP_LIM_OFS = 8'h0c;
	localparam logic [7:0] PRES_LIM_OFS = 8'h10;
	localparam logic [7:0] DP_DEV_OFS   = 8'h14;
	localparam logic [7:0] FLUCT_OFS    = 8'h18;
	localparam logic [7:0] CHECKS_OFS   = 8'h1c;
	localparam logic [7:0] SETTLE_OFS   = 8'h20;
	localparam logic [7:0] TIMEOUT_OFS  = 8'h24;
	localparam logic [7:0] VENT_OFS     = 8'h28;
	localparam logic [7:0] STATUS_OFS   = 8'h2c;
	localparam logic [7:0] REMAIN_OFS   = 8'h30;
	localparam logic [7:0] ZERO_OFS     = 8'h34;

	// Control register bit positions.
	localparam int CTRL_TIMER_EN  = 0;
	localparam int CTRL_HART_SRC  = 1;
	localparam int CTRL_SPLIT     = 2;
	localparam int CTRL_SOLENOID  = 3;
	localparam int CTRL_WET_MEDIA = 4;
	localparam int CTRL_STATIC_OK = 5;
	localparam int CTRL_SENSOR_OK = 6;
	localparam int CTRL_AO_DIRECT = 7;
	localparam int CTRL_W         = 8;

	// Command register bit positions; writing a one issues the command.
	localparam int CMD_START   = 0;
	localparam int CMD_EST_ZC  = 1;
	localparam int CMD_SET_Z   = 2;
	localparam int CMD_RESTORE = 3;
	localparam int CMD_VENT    = 4;

	// Reset values.
	localparam logic [CTRL_W-1:0] CTRL_RST   = 8'h01;
	localparam logic [15:0]       TIMER_RST  = 16'h01e0;
	localparam logic [15:0]       LIMIT_RST  = 16'h0010;
	localparam logic [15:0]       CHECKS_RST = 16'h0008;
	localparam logic [15:0]       SETTLE_RST = 16'h000a;
	localparam logic [15:0]       TMO_RST    = 16'h003c;
	localparam logic [15:0]       VENT_RST   = 16'h0003;

	// Timing constants.
	localparam int CHECK_MS      = 250;
	localparam int MS_PER_S      = 1000;
	localparam logic [31:0] S_PER_MIN = 32'h0000_003c;

	typedef enum logic [3:0] {
		PH_MEASURE, PH_ISOLATE, PH_JOIN, PH_CALIB, PH_HOLD_ZERO,
		PH_SEPARATE, PH_RECONNECT, PH_SETTLE, PH_VENT
	} phase_type;

	// Live measurement inputs.
	typedef struct packed {
		logic signed [15:0] ddp_first;
		logic signed [15:0] ddp_second;
		logic signed [15:0] cell_temp;
		logic signed [15:0] static_press;
		logic signed [15:0] sensor_press;
		logic        [15:0] loop_current;
	} meas_type;

	// Valve drive towards the valve unit.
	typedef struct packed {
		logic isolate;
		logic join_chambers;
	} valve_type;

endpackage

/* File: verif/zero_cal_chk.sv */
// Checker for the calibration sequencer: valve order, freezing and flagging at the ports.
// Assumes it is bound to the sequencer's top module and sees only its ports.
`timescale 1ns/1ps
module zero_cal_chk
	import zero_cal_pkg::*;
(
	// Clock and reset.
	input wire logic                    clk_sys_i,
	input wire logic                    reset_n_i,
	// Observed ports.
	input wire logic                    meas_valid_i,
	input wire zero_cal_pkg::meas_type  meas_i,
	input wire logic signed [15:0]      digital_diff_pressure_first_o,
	input wire logic signed [15:0]      digital_diff_pressure_second_o,
	input wire logic signed [15:0]      derived_diff_pressure_o,
	input wire zero_cal_pkg::meas_type  held_meas_o,
	input wire logic        [15:0]      analog_output_one_o,
	input wire logic        [31:0]      totaliser_o,
	input wire zero_cal_pkg::valve_type valve_o,
	input wire logic                    cal_active_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	property p_join_after_iso;
		$rose(valve_o.join_chambers) |-> $past(valve_o.isolate);
	endproperty
	a_join_after_iso: assert property (p_join_after_iso) else $error("chambers joined before isolation");
	property p_iso_first;
		$rose(valve_o.isolate) |-> !valve_o.join_chambers;
	endproperty
	a_iso_first: assert property (p_iso_first) else $error("isolation began with chambers joined");
	property p_sep_before_recon;
		$fell(valve_o.isolate) |-> !$past(valve_o.join_chambers);
	endproperty
	a_sep_before_recon: assert property (p_sep_before_recon) else $error("reconnected while joined");
	property p_valve_flag;
		(valve_o.isolate || valve_o.join_chambers) |-> cal_active_o;
	endproperty
	a_valve_flag: assert property (p_valve_flag) else $error("valves moved without busy flag");
	property p_held_frozen;
		cal_active_o && $past(cal_active_o) |-> $stable(held_meas_o);
	endproperty
	a_held_frozen: assert property (p_held_frozen) else $error("held inputs moved in calibration");
	property p_dp_frozen;
		cal_active_o && $past(cal_active_o) |-> $stable(derived_diff_pressure_o);
	endproperty
	a_dp_frozen: assert property (p_dp_frozen) else $error("derived pressure moved in calibration");
	property p_ao_hold;
		cal_active_o && $past(cal_active_o) |-> $stable(analog_output_one_o);
	endproperty
	a_ao_hold: assert property (p_ao_hold) else $error("analog output moved in calibration");
	property p_ddp_live;
		digital_diff_pressure_first_o == meas_i.ddp_first
			&& digital_diff_pressure_second_o == meas_i.ddp_second;
	endproperty
	a_ddp_live: assert property (p_ddp_live) else $error("digital readings not live");
	property p_tot_counts;
		meas_valid_i && cal_active_o |=> totaliser_o == $past(totaliser_o)
			+ {{16{$past(derived_diff_pressure_o[15])}}, $past(derived_diff_pressure_o)};
	endproperty
	a_tot_counts: assert property (p_tot_counts) else $error("totaliser stalled in calibration");
	property p_settle_gap;
		$fell(valve_o.isolate) |-> cal_active_o [*8];
	endproperty
	a_settle_gap: assert property (p_settle_gap) else $error("measurement resumed without settling");

	c_join: cover property ($rose(valve_o.join_chambers));
	c_done: cover property ($fell(cal_active_o));
	c_tot: cover property (meas_valid_i && cal_active_o);
endmodule

bind zero_point_calibration_sequencer zero_cal_chk u_chk (.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i), .meas_valid_i(meas_valid_i), .meas_i(meas_i),
	.digital_diff_pressure_first_o(digital_diff_pressure_first_o),
	.digital_diff_pressure_second_o(digital_diff_pressure_second_o),
	.derived_diff_pressure_o(derived_diff_pressure_o), .held_meas_o(held_meas_o),
	.analog_output_one_o(analog_output_one_o), .totaliser_o(totaliser_o),
	.valve_o(valve_o), .cal_active_o(cal_active_o));

/* File: verif/dp_transmitter_model.sv */
// Behavioural transmitter behind the valve unit, driven by the sequencer's valve outputs.
// Assumes the bench supplies process values and the offset read with joined chambers.
`timescale 1ns/1ps
module dp_transmitter_model
	import zero_cal_pkg::*;
(
	// Clock.
	input  wire logic                    clk_sys_i,
	// Valve drive and process.
	input  wire zero_cal_pkg::valve_type valve_i,
	input  wire zero_cal_pkg::meas_type  process_i,
	input  wire logic [15:0]             zero_first_i,
	input  wire logic [15:0]             zero_second_i,
	// Transmitter readings.
	output zero_cal_pkg::meas_type       meas_o
);
	// An isolated cell keeps the pressure it trapped; joined chambers read the bench offset whether isolated or not.
	always @(posedge clk_sys_i) begin
		meas_o <= process_i;
		if (valve_i.join_chambers) begin
			meas_o.ddp_first  <= zero_first_i;
			meas_o.ddp_second <= zero_second_i;
		end else if (valve_i.isolate) begin
			meas_o.ddp_first  <= meas_o.ddp_first;
			meas_o.ddp_second <= meas_o.ddp_second;
		end
	end
endmodule

/* File: verif/zero_point_calibration_sequencer_test.sv */
// Testbench for the calibration sequencer: register access, triggers and manual commands.
// Assumes a single AHB-Lite slave and the transmitter model on the valve side.
`timescale 1ns/1ps
module zero_point_calibration_sequencer_test;
	import zero_cal_pkg::*;
	localparam int HZ = 1000;
	logic        clk_sys     = 1'b0;
	logic        reset_n     = 1'b0;
	logic        hsel        = 1'b0;
	logic [31:0] haddr       = 32'h0;
	logic [1:0]  htrans      = 2'b00;
	logic        hwrite      = 1'b0;
	logic [31:0] hwdata      = 32'h0;
	logic [31:0] hrdata;
	logic        hready;
	meas_type    proc_meas   = '{16'h0064, 16'h0032, 16'h0, 16'h0, 16'h0, 16'h1234};
	meas_type    meas;
	meas_type    held;
	logic        meas_valid  = 1'b0;
	logic        ext_trigger = 1'b0;
	logic [15:0] zero_first  = 16'h0005;
	logic [15:0] zero_second = 16'hfffd;
	logic [15:0] digital_diff_pressure_first;
	logic [15:0] dp1;
	logic [15:0] dp2;
	logic [15:0] ao;
	valve_type   valve;
	logic        cal_active;
	logic [31:0] rd;
	int          fails       = 0;
	int          num_checks  = 0;
	int          guard;
	int          n;
	logic [7:0]  ofs [14]    = '{CTRL_OFS, TIMER_OFS, TEMP_LIM_OFS, PRES_LIM_OFS, DP_DEV_OFS,
		FLUCT_OFS, CHECKS_OFS, SETTLE_OFS, TIMEOUT_OFS, VENT_OFS, STATUS_OFS, REMAIN_OFS, ZERO_OFS, 8'h3c};
	logic [31:0] rst [14]    = '{32'h1, 32'h1e0, 32'h10, 32'h10, 32'h10, 32'h10, 32'h8, 32'ha,
		32'h3c, 32'h3, 32'h0, 32'h7080, 32'h0, 32'h0};

	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) meas_valid <= ~meas_valid;

	zero_point_calibration_sequencer #(.CLK_HZ(HZ), .VALVE_STEP_CYCLES(10)) u_dut (
		.clk_sys_i(clk_sys), .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
		.meas_i(meas), .meas_valid_i(meas_valid), .ext_trigger_i(ext_trigger),
		.digital_diff_pressure_first_o(digital_diff_pressure_first), .digital_diff_pressure_second_o(),
		.derived_diff_pressure_o(dp1), .derived_diff_pressure_second_o(dp2), .held_meas_o(held),
		.analog_output_one_o(ao), .totaliser_o(), .valve_o(valve), .cal_active_o(cal_active));

	dp_transmitter_model u_model (.clk_sys_i(clk_sys), .valve_i(valve), .process_i(proc_meas),
		.zero_first_i(zero_first), .zero_second_i(zero_second), .meas_o(meas));

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Ready is looked at mid-cycle, where it holds the value the next rising edge samples.
	task automatic ready_edge(output logic r);
		@(negedge clk_sys);
		r = hready;
		rd = hrdata;
		guard++;
		@(posedge clk_sys);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		logic r;
		@(posedge clk_sys);
		guard = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do ready_edge(r); while (r !== 1'b1 && guard < 50);
		htrans <= 2'b00;
		hwdata <= wd;
		do ready_edge(r); while (r !== 1'b1 && guard < 50);
		if (guard >= 50) begin
			fails++;
			final_report();
		end
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic wait_for(input logic sel, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		@(negedge clk_sys);
		while ((sel ? cal_active : valve.isolate) !== lvl && cnt < lim) begin
			@(negedge clk_sys);
			cnt++;
		end
		if (cnt >= lim) begin
			fails++;
			final_report();
		end
	endtask
	task automatic finish_cal();
		wait_for(1'b0, 1'b0, 4000, n);
		wait_for(1'b1, 1'b0, 3000, n);
		check(32'(n >= HZ - 1), 32'h1);
	endtask
	task automatic quiet_check();
		repeat (5) @(negedge clk_sys);
		check(32'(cal_active), 32'h0);
	endtask
	task automatic pulse_ext();
		@(posedge clk_sys);
		ext_trigger <= 1'b1;
		@(posedge clk_sys);
		ext_trigger <= 1'b0;
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			expect_reg(ofs[i], rst[i]);
		end
		bus(1'b1, CHECKS_OFS, 32'h2);
		bus(1'b1, SETTLE_OFS, 32'h2);
		bus(1'b1, CTRL_OFS, 32'h0);
		expect_reg(REMAIN_OFS, 32'h0);
		expect_reg(STATUS_OFS, 32'h20);
		pulse_ext();
		quiet_check();
		bus(1'b1, CTRL_OFS, 32'h7);
		pulse_ext();
		wait_for(1'b1, 1'b1, 4, n);
		proc_meas.cell_temp <= 16'h0007;
		repeat (40) @(negedge clk_sys);
		check({16'h0, digital_diff_pressure_first}, 32'h5);
		check({16'h0, dp1}, 32'h64);
		check({16'h0, held.cell_temp}, 32'h0);
		pulse_ext();
		finish_cal();
		expect_reg(ZERO_OFS, 32'hfffd0005);
		check(32'(cal_active), 32'h0);
		check({16'h0, dp1}, 32'h5f);
		check({16'h0, dp2}, 32'h35);
		zero_first <= 16'h0030;
		zero_second <= 16'h0030;
		proc_meas.cell_temp <= 16'h0017;
		quiet_check();
		@(posedge clk_sys);
		proc_meas.cell_temp <= 16'h0018;
		wait_for(1'b1, 1'b1, 4, n);
		finish_cal();
		expect_reg(ZERO_OFS, 32'hfffd0005);
		bus(1'b0, STATUS_OFS, 32'h0);
		check({31'h0, rd[7]}, 32'h1);
		zero_first <= 16'h0005;
		zero_second <= 16'hfffd;
		proc_meas.sensor_press <= 16'h0040;
		proc_meas.static_press <= 16'h0040;
		quiet_check();
		bus(1'b1, CTRL_OFS, 32'h47);
		wait_for(1'b1, 1'b1, 4, n);
		finish_cal();
		bus(1'b1, CTRL_OFS, 32'h67);
		proc_meas.static_press <= 16'h0051;
		wait_for(1'b1, 1'b1, 4, n);
		finish_cal();
		bus(1'b1, CTRL_OFS, 32'he7);
		repeat (3) @(negedge clk_sys);
		check({16'h0, ao}, 32'h1234);
		bus(1'b1, CMD_OFS, 32'h4);
		expect_reg(ZERO_OFS, 32'hfffd0005);
		zero_first <= 16'h0040;
		bus(1'b1, CMD_OFS, 32'h2);
		for (int i = 0; i < 200 && rd[3:0] !== PH_HOLD_ZERO; i++) begin
			bus(1'b0, STATUS_OFS, 32'h0);
		end
		bus(1'b1, CMD_OFS, 32'h1);
		bus(1'b0, STATUS_OFS, 32'h0);
		check({28'h0, rd[3:0]}, {28'h0, PH_HOLD_ZERO});
		bus(1'b1, CMD_OFS, 32'h4);
		expect_reg(ZERO_OFS, 32'hfffd0040);
		bus(1'b1, CMD_OFS, 32'h8);
		finish_cal();
		bus(1'b1, CMD_OFS, 32'h10);
		quiet_check();
		bus(1'b1, CTRL_OFS, 32'hff);
		bus(1'b1, CMD_OFS, 32'h10);
		wait_for(1'b1, 1'b1, 4, n);
		finish_cal();
		bus(1'b1, TIMER_OFS, 32'h1);
		bus(1'b0, REMAIN_OFS, 32'h0);
		check(32'(rd == 32'h3c || rd == 32'h3b), 32'h1);
		wait_for(1'b1, 1'b1, 62000, n);
		check(32'(n >= 58 * HZ), 32'h1);
		finish_cal();
		final_report();
	end
endmodule
